// file: design/ccp_channel0.sv
// Purpose: channel 0 mode control, compare value and apb registers
// Assumes: counter value and step from same-clock counter logic
// Notes: apb answers with no wait state
`timescale 1ns/100ps
`default_nettype none
`include "ccp_params.svh"
module ccp_channel0
	import ccp_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// shared counter
	input  wire logic [15:0] counter_value,
	input  wire logic        counter_step,
	// pins
	input  wire logic        chan0_input_pin,
	output logic             chan0_output_pin,
	// interrupt
	output logic             irq
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [7:0]  chan0_mode_reg;
	logic [7:0]  chan0_compare_low;
	logic [7:0]  chan0_compare_high;
	logic [7:0]  reload_low;
	logic [7:0]  reload_high;
	logic        reload_view_select;
	logic [1:0]  cycle_length_select;
	logic        chan0_event_flag;
	logic [2:0]  irq_status;
	logic [2:0]  irq_enable;
	logic        wr_en;
	logic        rd_setup;
	logic        lane0;
	logic [7:0]  wbyte;
	logic        rise;
	logic        fall;
	logic        capture;
	logic        wr_mode;
	logic        wr_low;
	logic        wr_high;
	logic        wr_cfg;
	logic        wr_flag;
	logic        wr_clear;
	logic        wr_ena;
	logic        pulse_narrow;
	logic        freq_mode;
	logic [7:0]  next_low;
	logic [7:0]  next_high;
	logic [2:0]  event_set;
	logic [2:0]  clear_mask;

	ccp_link_if link ();

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`OFS_MODE, `OFS_CMP_LOW, `OFS_CMP_HIGH, `OFS_PULSE_CFG,
			`OFS_EVENT_FLAG, `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE:
				mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped(paddr);
	assign wr_en    = psel & penable & pwrite & mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;
	assign lane0    = pstrb[0];
	assign wbyte    = pwdata[7:0];

	assign wr_mode  = wr_en & lane0 & hit(paddr, `OFS_MODE);
	assign wr_low   = wr_en & lane0 & hit(paddr, `OFS_CMP_LOW);
	assign wr_high  = wr_en & lane0 & hit(paddr, `OFS_CMP_HIGH);
	assign wr_cfg   = wr_en & lane0 & hit(paddr, `OFS_PULSE_CFG);
	assign wr_flag  = wr_en & lane0 & hit(paddr, `OFS_EVENT_FLAG);
	assign wr_clear = wr_en & lane0 & hit(paddr, `OFS_IRQ_CLEAR);
	assign wr_ena   = wr_en & lane0 & hit(paddr, `OFS_IRQ_ENABLE);

	// ---------------------------------------------------------------
	// input edges and capture
	// ---------------------------------------------------------------
	ccp_edge_sync u_edge (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin_in  (chan0_input_pin),
		.rise    (rise),
		.fall    (fall)
	);

	assign capture = (rise & chan0_mode_reg[`BIT_RISE_CAP])
		| (fall & chan0_mode_reg[`BIT_FALL_CAP]);

	// ---------------------------------------------------------------
	// waveform generator
	// ---------------------------------------------------------------
	assign link.mode          = chan0_mode_reg;
	assign link.cmp           = {chan0_compare_high, chan0_compare_low};
	assign link.cycle_len     = cycle_length_select;
	assign link.counter_value = counter_value;
	assign link.counter_step  = counter_step;

	ccp_wave_gen u_wave (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.link    (link.gen)
	);

	assign chan0_output_pin = link.pin;
	assign freq_mode    = chan0_mode_reg[`BIT_PIN_FLIP] & chan0_mode_reg[`BIT_PULSE_MODE];
	assign pulse_narrow = chan0_mode_reg[`BIT_PULSE_MODE] & ~chan0_mode_reg[`BIT_PIN_FLIP]
		& ~chan0_mode_reg[`BIT_WIDE_PULSE];

	// ---------------------------------------------------------------
	// mode register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chan0_mode_reg <= `RST_BYTE;
		end else if (wr_mode) begin
			chan0_mode_reg <= wbyte;
		end else if (wr_high) begin
			chan0_mode_reg[`BIT_CMP_EN] <= 1'b1;
		end else if (wr_low) begin
			chan0_mode_reg[`BIT_CMP_EN] <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// compare value next state
	// ---------------------------------------------------------------
	always_comb begin
		next_low  = chan0_compare_low;
		next_high = chan0_compare_high;
		if (capture) begin
			next_low  = counter_value[7:0];
			next_high = counter_value[15:8];
		end else if (link.wrap && pulse_narrow) begin
			if (cycle_length_select == `RST_CLEN) begin
				next_low = chan0_compare_high;
			end else begin
				next_low  = reload_low;
				next_high = reload_high;
			end
		end else if (link.match && freq_mode) begin
			next_low = 8'(chan0_compare_low + chan0_compare_high);
		end
		if (wr_low && !reload_view_select) begin
			next_low = wbyte;
		end
		if (wr_high && !reload_view_select) begin
			next_high = wbyte;
		end
	end

	// ---------------------------------------------------------------
	// compare and reload registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chan0_compare_low <= `RST_BYTE;
		end else begin
			chan0_compare_low <= next_low;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chan0_compare_high <= `RST_BYTE;
		end else begin
			chan0_compare_high <= next_high;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reload_low <= `RST_BYTE;
		end else if (wr_low && reload_view_select) begin
			reload_low <= wbyte;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reload_high <= `RST_BYTE;
		end else if (wr_high && reload_view_select) begin
			reload_high <= wbyte;
		end
	end

	// ---------------------------------------------------------------
	// pulse configuration
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reload_view_select <= 1'b0;
		end else if (wr_cfg) begin
			reload_view_select <= wbyte[`BIT_RELOAD_VIEW];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cycle_length_select <= `RST_CLEN;
		end else if (wr_cfg) begin
			cycle_length_select <= wbyte[1:0];
		end
	end

	// ---------------------------------------------------------------
	// event flag and interrupt status
	// ---------------------------------------------------------------
	assign event_set[`BIT_ST_FLAG]    = (link.match & chan0_mode_reg[`BIT_EQUAL_EV])
		| capture;
	assign event_set[`BIT_ST_CAPTURE] = capture;
	assign event_set[`BIT_ST_WRAP]    = link.wrap;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chan0_event_flag <= 1'b0;
		end else if (event_set[`BIT_ST_FLAG]) begin
			chan0_event_flag <= 1'b1;
		end else if (wr_flag) begin
			chan0_event_flag <= wbyte[0];
		end
	end

	// ---------------------------------------------------------------
	// sticky status bits, set wins over clear
	// ---------------------------------------------------------------
	assign clear_mask = wr_clear ? wbyte[2:0] : 3'h0;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_status
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					irq_status[i] <= 1'b0;
				end else if (event_set[i]) begin
					irq_status[i] <= 1'b1;
				end else if (clear_mask[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_enable <= 3'h0;
		end else if (wr_ena) begin
			irq_enable <= wbyte[2:0];
		end
	end

	assign irq = (chan0_event_flag & chan0_mode_reg[`BIT_FLAG_IRQ])
		| (|(irq_status[2:1] & irq_enable[2:1]));

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			case (paddr)
				`OFS_MODE:       prdata <= {24'h0, chan0_mode_reg};
				`OFS_CMP_LOW:    prdata <= {24'h0, reload_view_select ? reload_low
					: chan0_compare_low};
				`OFS_CMP_HIGH:   prdata <= {24'h0, reload_view_select ? reload_high
					: chan0_compare_high};
				`OFS_PULSE_CFG:  prdata <= {24'h0, reload_view_select, 5'h0,
					cycle_length_select};
				`OFS_EVENT_FLAG: prdata <= {31'h0, chan0_event_flag};
				`OFS_IRQ_STATUS: prdata <= {29'h0, irq_status};
				`OFS_IRQ_ENABLE: prdata <= {29'h0, irq_enable};
				default:         prdata <= 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: design/ccp_params.svh
// Purpose: constants for the counter array channel 0 block
// Assumes: 32-bit APB, byte-wide registers in the low lane
// Notes: offsets, field positions, reset values
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_MODE        8'h00
`define OFS_CMP_LOW     8'h04
`define OFS_CMP_HIGH    8'h08
`define OFS_PULSE_CFG   8'h0C
`define OFS_EVENT_FLAG  8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_CLEAR   8'h18
`define OFS_IRQ_ENABLE  8'h1C

// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define BIT_WIDE_PULSE  7
`define BIT_CMP_EN      6
`define BIT_RISE_CAP    5
`define BIT_FALL_CAP    4
`define BIT_EQUAL_EV    3
`define BIT_PIN_FLIP    2
`define BIT_PULSE_MODE  1
`define BIT_FLAG_IRQ    0

// ---------------------------------------------------------------
// pulse config and status fields
// ---------------------------------------------------------------
`define BIT_RELOAD_VIEW 7
`define BIT_ST_FLAG     0
`define BIT_ST_CAPTURE  1
`define BIT_ST_WRAP     2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_BYTE        8'h00
`define RST_CLEN        2'h0

`endif

// file: design/ccp_pkg.sv
// Purpose: shared types for the channel 0 block
// Assumes: constants in ccp_params.svh
// Notes: output behaviour selection
package ccp_pkg;
	typedef enum logic [2:0] {
		OUT_HOLD,
		OUT_TOGGLE,
		OUT_PWM_NARROW,
		OUT_PWM_WIDE,
		OUT_FREQ
	} out_mode_t;
endpackage

// file: design/ccp_link_if.sv
// Purpose: carrier between register side and waveform generator
// Assumes: one clock domain
// Notes: none
`timescale 1ns/100ps
`default_nettype none
interface ccp_link_if;
	logic [7:0]  mode;
	logic [15:0] cmp;
	logic [1:0]  cycle_len;
	logic [15:0] counter_value;
	logic        counter_step;
	logic        match;
	logic        wrap;
	logic        pin;
	modport ctl (output mode, cmp, cycle_len, counter_value, counter_step,
		input match, wrap, pin);
	modport gen (input mode, cmp, cycle_len, counter_value, counter_step,
		output match, wrap, pin);
endinterface
`default_nettype wire

// file: design/ccp_edge_sync.sv
// Purpose: synchronise the channel input pin and find its edges
// Assumes: pin is asynchronous to ref_clk
// Notes: edges are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module ccp_edge_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// pin
	input  wire logic pin_in,
	// edges
	output logic      rise,
	output logic      fall
);
	logic sync_a;
	logic sync_b;
	logic last;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
			last   <= sync_b;
		end
	end

	assign rise = sync_b & ~last;
	assign fall = ~sync_b & last;
endmodule
`default_nettype wire

// file: design/ccp_wave_gen.sv
// Purpose: compare, toggle, pwm and frequency output for channel 0
// Assumes: counter value and step come from the shared counter
// Notes: match and wrap are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "ccp_params.svh"
module ccp_wave_gen
	import ccp_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// link to register side
	ccp_link_if.gen   link
);
	out_mode_t   out_mode;
	logic [15:0] len_mask;
	logic [15:0] cnt_m;
	logic [15:0] cmp_m;
	logic        pulse_on;
	logic        wide;

	assign pulse_on = link.mode[`BIT_PULSE_MODE];
	assign wide     = link.mode[`BIT_WIDE_PULSE];

	// cycle length mask
	always_comb begin
		case (link.cycle_len)
			2'h0: len_mask = 16'h00FF;
			2'h1: len_mask = 16'h01FF;
			2'h2: len_mask = 16'h03FF;
			2'h3: len_mask = 16'h07FF;
			default: len_mask = 16'h00FF;
		endcase
	end

	// output behaviour selection
	always_comb begin
		if (link.mode[`BIT_PIN_FLIP] && pulse_on) begin
			out_mode = OUT_FREQ;
		end else if (pulse_on && wide) begin
			out_mode = OUT_PWM_WIDE;
		end else if (pulse_on) begin
			out_mode = OUT_PWM_NARROW;
		end else if (link.mode[`BIT_PIN_FLIP]) begin
			out_mode = OUT_TOGGLE;
		end else begin
			out_mode = OUT_HOLD;
		end
	end

	assign cnt_m = (out_mode == OUT_PWM_NARROW) ? (link.counter_value & len_mask)
		: link.counter_value;
	assign cmp_m = (out_mode == OUT_PWM_NARROW) ? (link.cmp & len_mask) : link.cmp;

	// comparator
	assign link.match = link.mode[`BIT_CMP_EN] & link.counter_step & (cnt_m == cmp_m);
	assign link.wrap  = link.counter_step & ((link.counter_value & len_mask) == len_mask);

	// pin driver
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			link.pin <= 1'b0;
		end else begin
			case (out_mode)
				OUT_TOGGLE, OUT_FREQ: begin
					if (link.match) begin
						link.pin <= ~link.pin;
					end
				end
				OUT_PWM_NARROW, OUT_PWM_WIDE: begin
					link.pin <= link.mode[`BIT_CMP_EN] & (cnt_m >= cmp_m);
				end
				default: begin
					link.pin <= link.pin;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: dv/ccp_channel0_props.sv
// Purpose: port checks for channel 0
// Assumes: mode and irq enable mirrored from apb writes
// Notes: bound into ccp_channel0
`timescale 1ns/100ps
`default_nettype none
module ccp_channel0_props (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// counter and pins
	input wire logic [15:0] counter_value,
	input wire logic        counter_step,
	input wire logic        chan0_input_pin,
	input wire logic        chan0_output_pin,
	input wire logic        irq
);
	// ----
	// mirrors
	// ----
	logic [7:0] mode_sh;
	logic [1:0] en_sh;
	logic       wr_hit;
	assign wr_hit = psel && penable && pwrite && pstrb[0];
	always_ff @(posedge ref_clk) begin
		if (sys_rst) mode_sh <= 8'h00;
		else if (wr_hit && paddr == 8'h00) mode_sh <= pwdata[7:0];
		else if (wr_hit && paddr == 8'h04) mode_sh <= mode_sh & 8'hBF;
		else if (wr_hit && paddr == 8'h08) mode_sh <= mode_sh | 8'h40;
	end
	always_ff @(posedge ref_clk) begin
		if (sys_rst) en_sh <= 2'h0;
		else if (wr_hit && paddr == 8'h1C) en_sh <= pwdata[2:1];
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence rd_mode_s;
		psel && penable && !pwrite && paddr == 8'h00;
	endsequence
	sequence flip_s;
		mode_sh[2:1] == 2'b10 && $past(mode_sh[2:1]) == 2'b10 && !$stable(chan0_output_pin);
	endsequence
	ready_always_a: assert property (pready) else $error("pready low");
	slverr_map_a: assert property (psel && penable |->
		pslverr == (paddr[1:0] != 2'b00 || paddr > 8'h1C)) else $error("pslverr wrong");
	upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	mode_readback_a: assert property (rd_mode_s |-> prdata[7:0] == mode_sh)
		else $error("mode readback wrong");
	hold_pin_a: assert property (mode_sh[2:1] == 2'b00 && $past(mode_sh[2:1]) == 2'b00
		|-> $stable(chan0_output_pin)) else $error("pin moved in hold");
	flip_cause_a: assert property (flip_s |-> $past(counter_step) && $past(mode_sh[6]))
		else $error("pin flip without match");
	irq_masked_a: assert property (!mode_sh[0] && en_sh == 2'b00 |-> !irq)
		else $error("irq while masked");
	reset_quiet_a: assert property ($past(sys_rst) |-> !irq && !chan0_output_pin)
		else $error("outputs active after reset");
endmodule
bind ccp_channel0 ccp_channel0_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.counter_value(counter_value), .counter_step(counter_step),
	.chan0_input_pin(chan0_input_pin), .chan0_output_pin(chan0_output_pin), .irq(irq));
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench for channel 0
// Assumes: zero wait state apb
// Notes: bench plays the shared counter
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [3:0]  pstrb = 4'h0;
	logic [15:0] counter_value = 16'h0;
	logic        counter_step = 1'b0, chan0_input_pin = 1'b0;
	logic        pready, pslverr, chan0_output_pin, irq, sv;
	int          mismatches = 0, compares = 0;
	always #10 ref_clk = ~ref_clk;
	ccp_channel0 u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
		.counter_step(counter_step), .chan0_input_pin(chan0_input_pin),
		.chan0_output_pin(chan0_output_pin), .irq(irq));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
		input logic [3:0] s);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= {24'h0, d};
		pstrb   <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rv = prdata;
		sv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, d, 4'h1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 8'h00, 4'h0);
		chk(rv, e);
	endtask
	task automatic step(input logic [15:0] v);
		counter_value <= v;
		counter_step  <= 1'b1;
		@(posedge ref_clk);
		counter_step  <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic cap(input logic lvl, input logic [15:0] v, input logic [7:0] e);
		counter_value   <= v;
		chan0_input_pin <= lvl;
		repeat (6) @(posedge ref_clk);
		rdc(8'h04, {24'h0, e});
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end
	// ----
	// tests
	// ----
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		for (int a = 0; a < 32; a += 4)
			if (a != 24) rdc(a[7:0], 32'h0);
		apb(8'h20, 1'b0, 8'h00, 4'h0);
		chk(32'(sv), 32'h1);
		wr(8'h00, 8'hBF);
		rdc(8'h00, 32'hBF);
		wr(8'h08, 8'h12);
		rdc(8'h00, 32'hFF);
		apb(8'h04, 1'b1, 8'h34, 4'h0);
		rdc(8'h00, 32'hFF);
		wr(8'h04, 8'h34);
		rdc(8'h00, 32'hBF);
		rdc(8'h04, 32'h34);
		wr(8'h0C, 8'h80);
		wr(8'h04, 8'h5A);
		rdc(8'h04, 32'h5A);
		wr(8'h0C, 8'h00);
		rdc(8'h04, 32'h34);
		wr(8'h00, 8'h08);
		step(16'h1234);
		rdc(8'h10, 32'h0);
		wr(8'h00, 8'h49);
		step(16'h1234);
		rdc(8'h10, 32'h1);
		chk(32'(irq), 32'h1);
		wr(8'h00, 8'h48);
		chk(32'(irq), 32'h0);
		wr(8'h10, 8'h00);
		wr(8'h00, 8'h44);
		step(16'h1234);
		chk(32'(chan0_output_pin), 32'h1);
		step(16'h1234);
		chk(32'(chan0_output_pin), 32'h0);
		wr(8'h00, 8'h46);
		step(16'h1234);
		chk(32'(chan0_output_pin), 32'h1);
		rdc(8'h04, 32'h46);
		wr(8'h04, 8'h80);
		wr(8'h08, 8'h80);
		wr(8'h00, 8'h42);
		step(16'h7F90);
		chk(32'(chan0_output_pin), 32'h1);
		step(16'h0170);
		chk(32'(chan0_output_pin), 32'h0);
		wr(8'h0C, 8'h01);
		step(16'h0170);
		chk(32'(chan0_output_pin), 32'h1);
		wr(8'h00, 8'hC2);
		step(16'h7F90);
		chk(32'(chan0_output_pin), 32'h0);
		wr(8'h00, 8'h42);
		step(16'h01FF);
		rdc(8'h04, 32'h5A);
		wr(8'h0C, 8'h00);
		wr(8'h10, 8'h00);
		wr(8'h1C, 8'h02);
		wr(8'h00, 8'h20);
		cap(1'b1, 16'h5678, 8'h78);
		rdc(8'h08, 32'h56);
		rdc(8'h10, 32'h1);
		chk(32'(irq), 32'h1);
		wr(8'h18, 8'h02);
		chk(32'(irq), 32'h0);
		cap(1'b0, 16'h9ABC, 8'h78);
		wr(8'h00, 8'h10);
		cap(1'b1, 16'h2222, 8'h78);
		cap(1'b0, 16'h9ABC, 8'hBC);
		wr(8'h00, 8'h30);
		cap(1'b1, 16'h1111, 8'h11);
		cap(1'b0, 16'h3333, 8'h33);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		chk(32'(irq), 32'h0);
		rdc(8'h04, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
